// ==== pkg/dacrt_defines.svh ====
`ifndef DACRT_DEFINES_SVH
`define DACRT_DEFINES_SVH
`define DACRT_CLK_MHZ        40
`define DACRT_T_CONV14_NS    680
`define DACRT_T_CONV12_NS    610
`define DACRT_T_BUSY_NS      40
`define DACRT_CONV14_CYC     ((`DACRT_T_CONV14_NS * `DACRT_CLK_MHZ) / 1000)
`define DACRT_CONV12_CYC     ((`DACRT_T_CONV12_NS * `DACRT_CLK_MHZ) / 1000)
`define DACRT_BUSY_CYC       (((`DACRT_T_BUSY_NS * `DACRT_CLK_MHZ) / 1000) > 0 ? \
                              ((`DACRT_T_BUSY_NS * `DACRT_CLK_MHZ) / 1000) : 1)
// Cycles lost to the pin synchroniser and the closing edge, taken off the conversion count.
`define DACRT_PIN_LAT_CYC    4
`define DACRT_FRAME_BITS     28
`define DACRT_WORD_BITS      14
`define DACRT_FIFO_DEPTH     16
`define DACRT_FIFO_AW        4
`define DACRT_PAIR_W         28
`endif

// ==== pkg/dacrt_pkg.sv ====
`default_nettype none
package dacrt_pkg;
   typedef enum logic [1:0] {dacrt_idle, dacrt_conv, dacrt_done} dacrt_state_type;
endpackage : dacrt_pkg
`default_nettype wire

// ==== design/dacrt_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dacrt_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wp_ff;
   logic [AW:0]      rp_ff;
   logic             empty;
   logic             full;
   logic             do_rd;
   logic [AW:0]      level;
   assign empty    = (wp_ff == rp_ff);
   // The output register holds a word too, so it counts towards the depth.
   assign level    = (wp_ff - rp_ff) + {{AW{1'b0}}, out_valid};
   assign full     = (level == (AW+1)'(DEPTH));
   assign in_ready = !full;
   assign do_rd    = !empty && (!out_valid || out_ready);
   always_ff @(posedge mclk) begin
      if (in_valid && !full) begin
         mem_ff[wp_ff[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         wp_ff <= '0;
      end else if (in_valid && !full) begin
         wp_ff <= wp_ff + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         rp_ff     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (do_rd) begin
         rp_ff     <= rp_ff + 1'b1;
         out_valid <= 1'b1;
         out_data  <= mem_ff[rp_ff[AW-1:0]];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : dacrt_fifo
`default_nettype wire

// ==== design/dacrt_top.sv ====
// Function
// - BUSY falls within 680 ns (14-bit) or 610 ns (12-bit) after convert start; with no sample pair queued, the design holds BUSY high until one arrives.
// - BUSY rises within 40 ns of the convert-start falling edge; the design takes two to three mclk cycles.
// - With select already low, the MSB is on the outputs when BUSY falls.
// - Outputs leave high impedance within 10 ns of select falling; the design takes two to three mclk cycles.
// - Outputs return to high impedance within 10 ns of select rising; the design takes two to three mclk cycles.
// - Results shift out MSB first, one bit per serial clock falling edge.
// - Fourteen further clocks deliver the other converter's result, 12-bit padded by zeros.
// - The pair select is sampled on BUSY rising for the next conversion.
// - Both converters' results appear together, one on each output.
`timescale 1ns/1ps
`default_nettype none
`include "dacrt_defines.svh"
module dacrt_top
   import dacrt_pkg::*;
#(
   parameter bit RES14 = 1'b1
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        convert_start_n,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        addr,
   input  wire logic        smp_valid,
   output logic             smp_ready,
   input  wire logic [13:0] smp_a,
   input  wire logic [13:0] smp_b,
   output logic             smp_addr,
   output logic             busy,
   output logic             serial_out_a,
   output logic             serial_out_a_oe,
   output logic             serial_out_b,
   output logic             serial_out_b_oe
);
   localparam logic [9:0] CONV_CYC = RES14 ? 10'(`DACRT_CONV14_CYC) : 10'(`DACRT_CONV12_CYC);
   localparam logic [9:0] DONE_CNT = CONV_CYC - 10'(`DACRT_PIN_LAT_CYC);
   localparam logic [4:0] FRAME    = 5'(`DACRT_FRAME_BITS);
   dacrt_state_type state_ff;
   logic [2:0]  cnv_sync_ff;
   logic [1:0]  cs_sync_ff;
   logic [2:0]  sclk_sync_ff;
   logic [1:0]  addr_sync_ff;
   logic [9:0]  cnt_ff;
   logic        addr_ff;
   logic [27:0] sh_a_ff;
   logic [27:0] sh_b_ff;
   logic [4:0]  bit_ff;
   logic        q_valid;
   logic        q_ready;
   logic [27:0] q_data;
   logic        cnv_fall;
   logic        sclk_fall;
   logic        cs_low;
   logic        conv_end;
   logic [13:0] wa;
   logic [13:0] wb;
   assign cnv_fall  = cnv_sync_ff[2] && !cnv_sync_ff[1];
   assign sclk_fall = sclk_sync_ff[2] && !sclk_sync_ff[1];
   assign cs_low    = !cs_sync_ff[1];
   assign conv_end  = (state_ff == dacrt_conv) && (cnt_ff == DONE_CNT) && q_valid;
   assign q_ready   = conv_end;
   assign smp_addr  = addr_ff;
   assign wa = RES14 ? q_data[27:14] : {q_data[25:14], 2'b00};
   assign wb = RES14 ? q_data[13:0]  : {q_data[11:0], 2'b00};
   dacrt_fifo #(
      .WIDTH (`DACRT_PAIR_W),
      .DEPTH (`DACRT_FIFO_DEPTH),
      .AW    (`DACRT_FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (smp_valid),
      .in_ready  (smp_ready),
      .in_data   ({smp_a, smp_b}),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_data)
   );
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnv_sync_ff  <= 3'b111;
         cs_sync_ff   <= 2'b11;
         sclk_sync_ff <= 3'b000;
         addr_sync_ff <= 2'b00;
      end else begin
         cnv_sync_ff  <= {cnv_sync_ff[1:0], convert_start_n};
         cs_sync_ff   <= {cs_sync_ff[0], cs_n};
         sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
         addr_sync_ff <= {addr_sync_ff[0], addr};
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= dacrt_idle;
         cnt_ff   <= '0;
         busy     <= 1'b0;
      end else begin
         unique case (state_ff)
            dacrt_idle: begin
               if (cnv_fall) begin
                  state_ff <= dacrt_conv;
                  cnt_ff   <= '0;
                  busy     <= 1'b1;
               end
            end
            dacrt_conv: begin
               if (conv_end) begin
                  state_ff <= dacrt_done;
                  busy     <= 1'b0;
               end else if (cnt_ff != DONE_CNT) begin
                  cnt_ff <= cnt_ff + 10'h001;
               end
            end
            dacrt_done: begin
               state_ff <= dacrt_idle;
            end
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_ff <= 1'b0;
      end else if (state_ff == dacrt_idle && cnv_fall) begin
         addr_ff <= addr_sync_ff[1];
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         sh_a_ff <= '0;
         sh_b_ff <= '0;
         bit_ff  <= '0;
      end else if (conv_end) begin
         sh_a_ff <= {wa, wb};
         sh_b_ff <= {wb, wa};
         bit_ff  <= '0;
      end else if (!cs_low) begin
         bit_ff <= '0;
      end else if (sclk_fall && bit_ff != FRAME) begin
         sh_a_ff <= {sh_a_ff[26:0], 1'b0};
         sh_b_ff <= {sh_b_ff[26:0], 1'b0};
         bit_ff  <= bit_ff + 5'h01;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         serial_out_a    <= 1'b0;
         serial_out_b    <= 1'b0;
         serial_out_a_oe <= 1'b0;
         serial_out_b_oe <= 1'b0;
      end else begin
         serial_out_a_oe <= cs_low;
         serial_out_b_oe <= cs_low;
         serial_out_a    <= conv_end ? wa[13] : sh_a_ff[27];
         serial_out_b    <= conv_end ? wb[13] : sh_b_ff[27];
      end
   end
endmodule : dacrt_top
`default_nettype wire

// ==== dv/dacrt_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module dacrt_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic convert_start_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic busy,
   input wire logic smp_addr,
   input wire logic serial_out_a,
   input wire logic serial_out_a_oe,
   input wire logic serial_out_b_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   busy_rise_a: assert property ($fell(convert_start_n) && !busy |-> ##[1:5] busy)
      else $error("busy rise late");
   conv_time_a: assert property ($rose(busy) |-> ##[1:24] !busy)
      else $error("conversion too long");
   oe_on_a: assert property ($fell(cs_n) |-> ##[1:4] serial_out_a_oe && serial_out_b_oe)
      else $error("outputs not driven");
   oe_off_a: assert property ($rose(cs_n) |-> ##[1:4] !serial_out_a_oe && !serial_out_b_oe)
      else $error("outputs not released");
   oe_idle_a: assert property (cs_n [*5] |-> !serial_out_b_oe)
      else $error("output driven unselected");
   oe_pair_a: assert property (serial_out_a_oe == serial_out_b_oe)
      else $error("outputs differ in enable");
   addr_latch_a: assert property ($changed(smp_addr) |-> busy)
      else $error("pair select moved outside start");
   data_hold_a: assert property ((sclk && !busy && !cs_n) [*4] |=> $stable(serial_out_a))
      else $error("data moved without clock fall");
endmodule : dacrt_chk
`default_nettype wire

// ==== dv/dacrt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dacrt_host #(parameter int HALF = 4, parameter int WAKE = 2800) (
   input  wire logic mclk,
   input  wire logic busy,
   input  wire logic serial_out_a,
   input  wire logic serial_out_b,
   output logic      convert_start_n,
   output logic      cs_n,
   output logic      sclk
);
   initial begin
      convert_start_n = 1'b1;
      cs_n = 1'b1;
      sclk = 1'b1;
   end
   task automatic wake;
      repeat (WAKE) @(posedge mclk);
   endtask : wake
   task automatic frame(input logic early, output logic [27:0] ra, output logic [27:0] rb);
      int i;
      @(posedge mclk) convert_start_n <= 1'b0;
      repeat (2) @(posedge mclk);
      convert_start_n <= 1'b1;
      cs_n <= ~early;
      repeat (8) @(posedge mclk);
      for (i = 0; i < 64 && busy !== 1'b0; i++) @(negedge mclk);
      @(posedge mclk) cs_n <= 1'b0;
      repeat (6) @(posedge mclk);
      for (i = 0; i < 28; i++) begin
         ra = {ra[26:0], serial_out_a};
         rb = {rb[26:0], serial_out_b};
         sclk <= 1'b0;
         repeat (HALF) @(posedge mclk);
         sclk <= 1'b1;
         repeat (HALF) @(posedge mclk);
      end
      cs_n <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : frame
endmodule : dacrt_host
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 1'b0, rst = 1'b1, addr = 1'b0, smp_valid = 1'b0, rdy;
   logic [13:0] smp_a = 14'h0000, smp_b = 14'h0000;
   logic smp_ready, smp_addr, busy, serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe;
   logic convert_start_n, cs_n, sclk;
   logic smp_ready12, smp_addr12, busy12, so_a12, so_a12_oe, so_b12, so_b12_oe, rdy12;
   logic cnv12_n, cs12_n, sclk12, pin_a, pin_b, pin_a12, pin_b12;
   logic [27:0] ra, rb, e, q[$];
   logic [27:0] ra12, rb12;
   logic [31:0] lfsr = 32'h0000_0e7e;
   int n_mismatch = 0, tests_run = 0, n12 = 0;
   always #12.5 mclk = ~mclk;
   dacrt_top #(.RES14(1'b1)) i_dut (.mclk, .rst, .convert_start_n, .cs_n, .sclk, .addr, .smp_valid,
      .smp_ready, .smp_a, .smp_b, .smp_addr, .busy, .serial_out_a, .serial_out_a_oe, .serial_out_b, .serial_out_b_oe);
   // A released output reads back inverted, so sampling an undriven pin shows up as bad data.
   assign pin_a   = serial_out_a_oe ? serial_out_a : ~serial_out_a;
   assign pin_b   = serial_out_b_oe ? serial_out_b : ~serial_out_b;
   assign pin_a12 = so_a12_oe ? so_a12 : ~so_a12;
   assign pin_b12 = so_b12_oe ? so_b12 : ~so_b12;
   dacrt_top #(.RES14(1'b0)) i_dut12 (.mclk, .rst, .convert_start_n(cnv12_n), .cs_n(cs12_n), .sclk(sclk12), .addr,
      .smp_valid, .smp_ready(smp_ready12), .smp_a, .smp_b, .smp_addr(smp_addr12), .busy(busy12),
      .serial_out_a(so_a12), .serial_out_a_oe(so_a12_oe), .serial_out_b(so_b12), .serial_out_b_oe(so_b12_oe));
   dacrt_host i_host (.mclk, .busy, .serial_out_a(pin_a), .serial_out_b(pin_b), .convert_start_n, .cs_n, .sclk);
   dacrt_host i_host12 (.mclk, .busy(busy12), .serial_out_a(pin_a12), .serial_out_b(pin_b12),
      .convert_start_n(cnv12_n), .cs_n(cs12_n), .sclk(sclk12));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   function automatic logic [27:0] swap(input logic [27:0] p);
      return {p[13:0], p[27:14]};
   endfunction : swap
   function automatic logic [27:0] pad12(input logic [27:0] p);
      return {p[25:14], 2'b00, p[11:0], 2'b00};
   endfunction : pad12
   task automatic chk(input string nm, input logic [27:0] x, input logic [27:0] s);
      tests_run++;
      if (s !== x) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic new_pair;
      lfsr = nxt(lfsr);
      smp_a <= lfsr[13:0];
      smp_b <= lfsr[27:14];
   endtask : new_pair
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      smp_valid <= 1'b1;
      new_pair();
      for (int k = 0; k < 40; k++) begin
         @(negedge mclk) rdy = smp_ready;
         rdy12 = smp_ready12;
         @(posedge mclk);
         if (rdy12) n12++;
         if (rdy) begin
            q.push_back({smp_a, smp_b});
            new_pair();
         end
      end
      smp_valid <= 1'b0;
      chk("fill", 28'h000_0010, 28'(q.size()));
      chk("fill12", 28'h000_0010, 28'(n12));
      $display("fill done");
      fork
         i_host.wake();
         i_host12.wake();
      join
      for (int n = 0; n < 16; n++) begin
         lfsr = nxt(lfsr);
         addr <= lfsr[0];
         fork
            i_host.frame(lfsr[1], ra, rb);
            i_host12.frame(lfsr[2], ra12, rb12);
         join
         e = q.pop_front();
         chk("out_a", e, ra);
         chk("out_b", swap(e), rb);
         chk("pair", {27'h000_0000, lfsr[0]}, {27'h000_0000, smp_addr});
         chk("out_a12", pad12(e), ra12);
         chk("out_b12", pad12(swap(e)), rb12);
         chk("pair12", {27'h000_0000, lfsr[0]}, {27'h000_0000, smp_addr12});
         $display("frame %0d done", n);
      end
      conclude();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      conclude();
   end
endmodule : tb
bind dacrt_top dacrt_chk i_chk (.mclk, .rst, .convert_start_n, .cs_n, .sclk, .busy, .smp_addr, .serial_out_a,
   .serial_out_a_oe, .serial_out_b_oe);
`default_nettype wire
